// File: libuc_pkg.sv
/*
 * Package for the legacy bus bridge and serial-port control block:
 * register indices, field positions, reset values and carrier structs.
 * Assumes the host's I/O decoder presents one register access per cycle.
 */
`default_nettype none
package libuc_pkg;
    // Register indices on the local register port
    localparam logic [1:0] LIBUC_IDX_BAUD_MODE = 2'h0;
    localparam logic [1:0] LIBUC_IDX_FWD_CTRL1 = 2'h1;
    localparam logic [1:0] LIBUC_IDX_BUS_CTRL2 = 2'h2;
    // Field positions
    localparam int LIBUC_SCALE_BIT = 0;
    localparam int LIBUC_HIT_BIT = 7;
    localparam int LIBUC_CTRL2_EN_HI = 2;
    // Divisor shift in legacy interpretation
    localparam int LIBUC_DIV_SHIFT = 4;
    // Reset values
    localparam logic [7:0] LIBUC_BAUD_MODE_RST = 8'h00;
    localparam logic [7:0] LIBUC_FWD_CTRL1_RST = 8'h00;
    localparam logic [2:0] LIBUC_CTRL2_EN_RST = 3'h0;
    localparam logic LIBUC_HIT_RST = 1'b0;

    // Host register access, one cycle per strobe
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] idx;
        logic [7:0] wdata;
    } libuc_reg_req_t;

    // One decoded host I/O cycle
    typedef struct packed {
        logic valid;
        logic port1_win;
        logic port2_win;
        logic other_isa;
    } libuc_io_cycle_t;
endpackage : libuc_pkg
`default_nettype wire

// File: libuc_ctrl.sv
/*
 * Legacy bus bridge control: serial-port window forwarding, baud divisor
 * scaling, legacy interrupt forwarding and the sticky bus-hit flag.
 * Assumes address compare of the port windows is done upstream on sys_clk,
 * and that the legacy interrupt lines arrive asynchronously from pins.
 */
`timescale 1ns/1ps
`default_nettype none
module libuc_ctrl
    import libuc_pkg::*;
#(
    parameter int DIV_W = 16,
    parameter int NUM_LINES = 11
)
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Register port
    input wire libuc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Host I/O cycle decode
    input wire libuc_io_cycle_t io_cycle,
    input wire logic serial_port1_output_enable,
    input wire logic serial_port2_output_enable,
    output logic port1_select,
    output logic port2_select,
    output logic legacy_forward,
    // Serial port pin gating
    input wire logic [1:0] txd_raw,
    input wire logic [1:0] rts_raw,
    output logic [1:0] txd_out,
    output logic [1:0] rts_out,
    output logic [1:0] txd_oe,
    output logic [1:0] rts_oe,
    // Baud divisor
    input wire logic [DIV_W-1:0] divisor_prog,
    output logic [DIV_W+3:0] divisor_eff,
    // Legacy interrupt lines: 15,14,12,11,10,9,7,6,5,4,3 from msb
    input wire logic [NUM_LINES-1:0] legacy_irq_pin,
    output logic [NUM_LINES-1:0] serial_irq_slot
);
    // Refused at elaboration: the line map is fixed at eleven lines
    if (NUM_LINES != 11 || DIV_W < 1)
    begin : g_bad_params
        $error("libuc_ctrl: unsupported parameters");
    end

    // Matches a register access to an index
    function automatic logic reg_hit(input libuc_reg_req_t r,
                                     input logic [1:0] idx);
        reg_hit = r.idx == idx;
    endfunction : reg_hit

    logic scale_reg; // Shared divisor scaling bit
    logic [7:0] fwd_ctrl1_reg; // Lines 11..3 enables
    logic [2:0] ctrl2_en_reg; // Lines 15,14,12 enables
    logic hit_flag_reg; // Sticky legacy-bus hit
    logic hit_flag_next;
    logic [NUM_LINES-1:0] irq_meta_reg; // First sync stage only
    logic [NUM_LINES-1:0] irq_sync_reg;
    logic [NUM_LINES-1:0] line_en; // Concatenated enables
    logic hit_event; // Forwarded cycle this clock
    logic flag_rd; // Host read of control two

    // Window decode: a disabled port stops decoding its own range
    always_comb
    begin
        port1_select = io_cycle.port1_win && serial_port1_output_enable;
        port2_select = io_cycle.port2_win && serial_port2_output_enable;
        // Anything in a disabled window goes out on the legacy bus
        legacy_forward = io_cycle.other_isa
            || (io_cycle.port1_win && !serial_port1_output_enable)
            || (io_cycle.port2_win && !serial_port2_output_enable);
    end

    assign hit_event = io_cycle.valid && legacy_forward;
    assign flag_rd = reg_req.rd && reg_hit(reg_req, LIBUC_IDX_BUS_CTRL2);

    // Port outputs released while disabled; idle level on data is high
    always_comb
    begin
        txd_oe = {serial_port2_output_enable, serial_port1_output_enable};
        rts_oe = txd_oe;
        txd_out = txd_raw | ~txd_oe;
        rts_out = rts_raw | ~rts_oe;
    end

    // Scaling bit: only bit 0 is stored, the rest reads zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            scale_reg <= LIBUC_BAUD_MODE_RST[LIBUC_SCALE_BIT];
        else if (clk_en && reg_req.wr && reg_hit(reg_req, LIBUC_IDX_BAUD_MODE))
            scale_reg <= reg_req.wdata[LIBUC_SCALE_BIT];
    end

    // Effective divisor, registered so the UART cores see a clean value
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            divisor_eff <= '0;
        else if (clk_en)
        begin
            if (scale_reg)
                divisor_eff <= {4'h0, divisor_prog};
            else
                divisor_eff <= {divisor_prog, 4'h0};
        end
    end

    // Interrupt enables; control two keeps only bits 2-0 and the flag
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            fwd_ctrl1_reg <= LIBUC_FWD_CTRL1_RST;
            ctrl2_en_reg <= LIBUC_CTRL2_EN_RST;
        end
        else if (clk_en && reg_req.wr)
        begin
            if (reg_hit(reg_req, LIBUC_IDX_FWD_CTRL1))
                fwd_ctrl1_reg <= reg_req.wdata;
            if (reg_hit(reg_req, LIBUC_IDX_BUS_CTRL2))
                ctrl2_en_reg <= reg_req.wdata[LIBUC_CTRL2_EN_HI:0];
        end
    end

    // Sticky hit: a new hit beats the read clear, writes never touch it
    always_comb
    begin
        hit_flag_next = hit_flag_reg;
        if (flag_rd)
            hit_flag_next = 1'b0;
        if (hit_event)
            hit_flag_next = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            hit_flag_reg <= LIBUC_HIT_RST;
        else if (clk_en)
            hit_flag_reg <= hit_flag_next;
    end

    // Read data registered; reserved bits come back as zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_req.rd)
        begin
            unique case (reg_req.idx)
                LIBUC_IDX_BAUD_MODE: reg_rdata <= {7'h00, scale_reg};
                LIBUC_IDX_FWD_CTRL1: reg_rdata <= fwd_ctrl1_reg;
                LIBUC_IDX_BUS_CTRL2:
                    reg_rdata <= {hit_flag_reg, 4'h0, ctrl2_en_reg};
                default: reg_rdata <= 8'h00; // Unused index
            endcase
        end
    end

    // Pins cross into sys_clk through two flops before gating
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq_meta_reg <= '0;
            irq_sync_reg <= '0;
        end
        else if (clk_en)
        begin
            irq_meta_reg <= legacy_irq_pin;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    // Global serial enable deliberately plays no part here
    assign line_en = {ctrl2_en_reg, fwd_ctrl1_reg};

    // Active-high pass-through, no latching of the line level
    generate
        for (genvar i = 0; i < NUM_LINES; i++)
        begin : g_line
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    serial_irq_slot[i] <= 1'b0;
                else if (clk_en)
                    serial_irq_slot[i] <= irq_sync_reg[i] && line_en[i];
            end
        end
    endgenerate

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    fwd_disabled_a: assert property (io_cycle.port1_win
        && !serial_port1_output_enable |-> legacy_forward && !port1_select)
        else $error("disabled port window not forwarded");
    out_off_a: assert property (!serial_port2_output_enable
        |-> txd_oe[1] == 1'b0 && rts_oe[1] == 1'b0)
        else $error("disabled port still drives");
    div_legacy_a: assert property (clk_en && !scale_reg |=>
        divisor_eff == {$past(divisor_prog), 4'h0})
        else $error("legacy divisor not scaled");
    div_fast_a: assert property (clk_en && scale_reg |=>
        divisor_eff == {4'h0, $past(divisor_prog)})
        else $error("fast divisor modified");
    baud_read_a: assert property (clk_en && reg_req.rd
        && reg_req.idx == LIBUC_IDX_BAUD_MODE |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved baud bits nonzero");
    // Pin sampled at one edge reaches the slot two enabled edges later
    irq_pass_a: assert property ((clk_en && legacy_irq_pin[0])
        ##1 clk_en ##1 (clk_en && fwd_ctrl1_reg[0])
        |=> serial_irq_slot[0])
        else $error("enabled line not forwarded");
    irq_block_a: assert property (clk_en ##0 !ctrl2_en_reg[2] [*2]
        |-> !serial_irq_slot[10])
        else $error("blocked line forwarded");
    hit_set_a: assert property (clk_en && io_cycle.valid
        && legacy_forward |=> hit_flag_reg)
        else $error("hit flag not set");
    hit_clear_a: assert property (clk_en && flag_rd && !hit_event
        |=> !hit_flag_reg)
        else $error("hit flag not cleared on read");
    hit_hold_a: assert property (hit_flag_reg && !flag_rd
        |=> hit_flag_reg)
        else $error("hit flag dropped");

    hit_race_c: cover property (clk_en && flag_rd && hit_event);
    fast_mode_c: cover property (scale_reg ##1 !scale_reg);
    irq_fwd_c: cover property (serial_irq_slot[10] && serial_irq_slot[0]);
    port_fwd_c: cover property (io_cycle.valid && io_cycle.port2_win
        && legacy_forward);
endmodule : libuc_ctrl
`default_nettype wire

// File: libuc_isa_card_model.sv
/*
 * Behavioural expansion-card model driving the legacy interrupt lines.
 * Assumes the sequence asks for line levels; the card drives each line
 * just after the clock edge and holds it as a plain level.
 */
`timescale 1ns/1ps
`default_nettype none
module libuc_isa_card_model (
    // Clock
    input wire logic sys_clk,
    // Line levels asked for by the sequence
    input wire logic [10:0] line_req,
    // Legacy interrupt lines, high true
    output logic [10:0] irq_pin
);
    // Level held until the next request; no global mask on this side
    // The block's reset covers the lines until the first edge
    always @(posedge sys_clk) irq_pin <= line_req;
endmodule : libuc_isa_card_model
`default_nettype wire

// File: tb_libuc_ctrl.sv
/*
 * Self-checking bench for the legacy bus bridge control block.
 * Assumes the package register indices and the registered read path.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_libuc_ctrl;
    import libuc_pkg::*;
    // Stimulus and observation
    logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1;
    libuc_reg_req_t reg_req = '0;
    libuc_io_cycle_t io_cycle = '0;
    logic p1_en = 1'b1, p2_en = 1'b1;
    logic [15:0] divisor_prog = 16'h0000;
    logic [10:0] line_req = 11'h000, irq_pin, slot;
    logic [7:0] reg_rdata;
    logic [19:0] divisor_eff;
    logic [1:0] txd_out, rts_out, txd_oe, rts_oe;
    logic [1:0] txd_raw = 2'h0, rts_raw = 2'h0;
    logic port1_select, port2_select, legacy_forward;
    logic [10:0] pat [2] = '{11'h7ff, 11'h2aa};
    int n_mismatch = 0, tests_run = 0, cycles = 0;

    always #50 sys_clk = ~sys_clk;

    libuc_ctrl libuc_ctrl_inst (.sys_clk(sys_clk), .srst(srst),
        .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .io_cycle(io_cycle), .serial_port1_output_enable(p1_en),
        .serial_port2_output_enable(p2_en), .port1_select(port1_select),
        .port2_select(port2_select), .legacy_forward(legacy_forward),
        .txd_raw(txd_raw), .rts_raw(rts_raw), .txd_out(txd_out),
        .rts_out(rts_out), .txd_oe(txd_oe), .rts_oe(rts_oe),
        .divisor_prog(divisor_prog), .divisor_eff(divisor_eff),
        .legacy_irq_pin(irq_pin), .serial_irq_slot(slot));
    libuc_isa_card_model libuc_isa_card_model_inst (.sys_clk(sys_clk),
        .line_req(line_req), .irq_pin(irq_pin));

    task automatic conclude;
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask : chk

    // One register strobe, optionally with a forwarded cycle alongside
    task automatic access(input logic r, w, input logic [1:0] i,
                          input logic [7:0] d, input logic hit);
        @(posedge sys_clk);
        reg_req <= '{rd: r, wr: w, idx: i, wdata: d};
        io_cycle <= '{valid: hit, port1_win: 1'b0, port2_win: 1'b0,
                      other_isa: hit};
        @(posedge sys_clk);
        reg_req <= '0;
        io_cycle <= '0;
        #1;
    endtask : access

    task automatic rd(input logic [1:0] i, input logic [7:0] exp);
        access(1'b1, 1'b0, i, 8'h00, 1'b0);
        chk(20'(reg_rdata), 20'(exp));
    endtask : rd

    task automatic wr(input logic [1:0] i, input logic [7:0] d);
        access(1'b0, 1'b1, i, d, 1'b0);
    endtask : wr

    // Hang guard, well above the roughly 72 cycles the sequence needs
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd(LIBUC_IDX_BAUD_MODE, LIBUC_BAUD_MODE_RST);
        rd(LIBUC_IDX_FWD_CTRL1, LIBUC_FWD_CTRL1_RST);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h00);
        wr(LIBUC_IDX_BAUD_MODE, 8'hff);
        rd(LIBUC_IDX_BAUD_MODE, 8'h01);
        wr(LIBUC_IDX_BUS_CTRL2, 8'hff);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h07);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        // Divisor programmed only after fast mode is set
        @(posedge sys_clk);
        divisor_prog <= 16'h1234;
        repeat (2) @(posedge sys_clk);
        #1 chk(divisor_eff, 20'h01234);
        wr(LIBUC_IDX_BAUD_MODE, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk(divisor_eff, 20'h12340);
        // A write with the clock enable low must not land
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(LIBUC_IDX_FWD_CTRL1, 8'h3c);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(LIBUC_IDX_FWD_CTRL1, 8'h00);
        wr(LIBUC_IDX_FWD_CTRL1, 8'ha5);
        wr(LIBUC_IDX_BUS_CTRL2, 8'h05);
        rd(LIBUC_IDX_FWD_CTRL1, 8'ha5);
        foreach (pat[k])
        begin
            @(posedge sys_clk);
            line_req <= pat[k];
            repeat (6) @(posedge sys_clk);
            #1 chk(20'(slot), 20'(pat[k] & 11'h5a5));
        end
        // Port 1 disabled, its window must go to the legacy bus
        @(posedge sys_clk);
        p1_en <= 1'b0;
        io_cycle <= '{valid: 1'b1, port1_win: 1'b1, port2_win: 1'b0,
                      other_isa: 1'b0};
        #1 chk(20'({port1_select, legacy_forward, txd_out, rts_out, txd_oe,
                    rts_oe}), 20'h15a);
        @(posedge sys_clk);
        io_cycle <= '{valid: 1'b1, port1_win: 1'b0, port2_win: 1'b1,
                      other_isa: 1'b0};
        #1 chk(20'({port2_select, legacy_forward}), 20'h2);
        // Port 2 disabled: its pins released, its window forwarded
        @(posedge sys_clk);
        p1_en <= 1'b1;
        p2_en <= 1'b0;
        txd_raw <= 2'h1;
        #1 chk(20'({port2_select, legacy_forward, txd_out, rts_out, txd_oe,
                    rts_oe}), 20'h1e5);
        @(posedge sys_clk);
        io_cycle <= '0;
        p2_en <= 1'b1;
        wr(LIBUC_IDX_BUS_CTRL2, 8'h05);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h85);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h05);
        access(1'b1, 1'b0, LIBUC_IDX_BUS_CTRL2, 8'h00, 1'b1);
        chk(20'(reg_rdata), 20'h05);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h85);
        rd(LIBUC_IDX_BUS_CTRL2, 8'h05);
        conclude();
    end
endmodule : tb_libuc_ctrl
`default_nettype wire
